// *** scp_readout.sv ***
// Serial configuration memory: readout counter, cascade control, reset pin and test access port
`timescale 1ns/1ps
// Notes on behaviour
// - Counter steps on selected clock rise when enabled
// - Reset pin low: counter cleared, data floats
// - Pull reset pin low until power-on done
// - Chip enable high: standby, counter cleared, float
// - Configuration pulse lasts at least minimum width
// - Cascade low only enabled and past limit
// - Cascade returns high on reset or disable
// - Serial data leaves on single data pin
// - Data floats in programming mode unless clamped
// - Mode select on test clock rise steers controller
// - Test clock sequences all scan logic
// - Test data shifts into selected scan register
module scp_readout (
  input  wire logic SYS_CLK_I,
  input  wire logic RESET_N_I,
  input  wire logic CFG_CLK_I,
  input  wire logic CFG_CLK_SEL_I,
  input  wire logic CHIP_ENABLE_N_I,
  input  wire logic OE_RESET_N_I,
  output wire logic OE_RESET_N_O,
  output wire logic OE_RESET_N_OE_O,
  output wire logic SERIAL_DATA_OUT_O,
  output wire logic SERIAL_DATA_OUT_OE_O,
  output wire logic CASCADE_ENABLE_OUT_N_O,
  output wire logic RECONFIG_PULSE_N_O,
  output wire logic RECONFIG_PULSE_N_OE_O,
  input  wire logic TCK_I,
  input  wire logic TMS_I,
  input  wire logic TDI_I,
  output wire logic TDO_O,
  output wire logic TDO_OE_O
);
  import scp_pkg::*;

  function automatic logic rise(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction

  function automatic scp_tap_t tap_next(input scp_tap_t s, input logic tms);
    scp_tap_t n;
    n = TAP_RESET;
    case (s)
      TAP_RESET:  n = tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   n = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: n = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: n = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  n = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: n = tms ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  n = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: n = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: n = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: n = tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: n = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  n = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: n = tms ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  n = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: n = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: n = tms ? TAP_SEL_DR : TAP_IDLE;
      default:    n = TAP_RESET;
    endcase
    return n;
  endfunction

  logic [SYNC_W-1:0]    sync1_r;
  logic [SYNC_W-1:0]    sync2_r;
  logic [SYNC_W-1:0]    prev_r;
  logic [POR_CNT_W-1:0] por_cnt_r;
  logic                 por_done_r;
  logic [ADDR_W-1:0]    addr_r;
  logic                 past_r;
  logic [ADDR_W-1:0]    addr_nxt;
  logic [ADDR_W-1:0]    fetch_addr_r;
  logic                 fetch_done_r;
  logic [WORD_W-1:0]    mem_r [MEM_WORDS];
  scp_tap_t             tap_r;
  logic [IR_W-1:0]      ir_sh_r;
  logic [IR_W-1:0]      ir_r;
  logic [PROG_DR_W-1:0] dr_sh_r;
  logic                 byp_r;
  logic                 tdo_r;
  logic                 tdo_oe_r;
  logic                 isp_r;
  logic                 clamp_r;
  logic [CF_CNT_W-1:0]  cf_cnt_r;
  logic                 oe_low;
  logic                 enabled;
  logic                 cfg_rise;
  logic                 tck_rise;
  logic                 tck_fall;
  logic                 cf_start;
  logic                 prog_wr;

  scp_stream_if #(.W(BUF_WIDTH)) fill_if ();
  scp_stream_if #(.W(BUF_WIDTH)) drain_if ();

  // Every pin but the system clock and reset is sampled twice before use; the second stage and its delayed copy feed logic
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
    end else begin
      sync1_r <= {TDI_I, TMS_I, TCK_I, CFG_CLK_SEL_I, OE_RESET_N_I, CHIP_ENABLE_N_I, CFG_CLK_I};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      por_cnt_r  <= '0;
      por_done_r <= 1'b0;
    end else if (!por_done_r) begin
      por_cnt_r  <= por_cnt_r + POR_CNT_W'(1);
      por_done_r <= (por_cnt_r == POR_CYCLES - POR_CNT_W'(1));
    end
  end

  // The pin reads back our own pull, so the low also covers the power-on window
  assign oe_low   = ~sync2_r[S_OE_RST_N] | ~por_done_r;
  assign enabled  = ~sync2_r[S_CE_N] & ~oe_low;
  assign cfg_rise = rise(prev_r[S_CFG_CLK], sync2_r[S_CFG_CLK]) & sync2_r[S_CLK_SEL] & enabled;
  assign tck_rise = rise(prev_r[S_TCK], sync2_r[S_TCK]);
  assign tck_fall = rise(sync2_r[S_TCK], prev_r[S_TCK]);

  assign OE_RESET_N_O    = 1'b0;
  assign OE_RESET_N_OE_O = ~por_done_r;

  // Counter saturates at the limit; the step beyond it sets the past flag
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      addr_r <= '0;
      past_r <= 1'b0;
    end else if (!enabled) begin
      addr_r <= '0;
      past_r <= 1'b0;
    end else if (cfg_rise && !past_r) begin
      if (addr_r == COUNTER_LIMIT) begin
        past_r <= 1'b1;
      end else begin
        addr_r <= addr_r + ADDR_W'(1);
      end
    end
  end

  // Bit the counter shows after this edge; a refill after a write starts there
  assign addr_nxt = (cfg_rise && !past_r && addr_r != COUNTER_LIMIT) ? addr_r + ADDR_W'(1) : addr_r;

  // Fetch runs ahead of the counter into the buffer and stalls while it is full
  // A write drops the queued bits and refills, so no stale bit reaches the pin
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      fetch_addr_r <= '0;
      fetch_done_r <= 1'b0;
    end else if (!enabled) begin
      fetch_addr_r <= '0;
      fetch_done_r <= 1'b0;
    end else if (prog_wr) begin
      fetch_addr_r <= addr_nxt;
      fetch_done_r <= 1'b0;
    end else if (fill_if.valid && fill_if.ready) begin
      if (fetch_addr_r == COUNTER_LIMIT) begin
        fetch_done_r <= 1'b1;
      end else begin
        fetch_addr_r <= fetch_addr_r + ADDR_W'(1);
      end
    end
  end

  assign fill_if.valid  = enabled & ~fetch_done_r;
  assign fill_if.data   = mem_r[fetch_addr_r[ADDR_W-1:3]][fetch_addr_r[2:0]];
  assign drain_if.ready = cfg_rise & ~past_r;

  scp_buf #(
    .WIDTH (BUF_WIDTH),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RESET_N_I),
    .flush_i (~enabled | prog_wr),
    .fill    (fill_if),
    .drain   (drain_if)
  );

  assign SERIAL_DATA_OUT_O    = drain_if.data;
  assign SERIAL_DATA_OUT_OE_O = enabled & ~past_r & drain_if.valid & ~(isp_r & ~clamp_r);
  // Combinational so the cascade output drops out with no clock from the partner
  assign CASCADE_ENABLE_OUT_N_O = ~(enabled & past_r);

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tap_r <= TAP_RESET;
    end else if (tck_rise) begin
      tap_r <= tap_next(tap_r, sync2_r[S_TMS]);
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ir_sh_r <= '0;
      ir_r    <= IR_BYPASS;
    end else if (tck_rise) begin
      case (tap_r)
        TAP_RESET:  ir_r    <= IR_BYPASS;
        TAP_CAP_IR: ir_sh_r <= IR_CAPTURE;
        TAP_SH_IR:  ir_sh_r <= {sync2_r[S_TDI], ir_sh_r[IR_W-1:1]};
        TAP_UPD_IR: ir_r    <= ir_sh_r;
        default:    ir_r    <= ir_r;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      dr_sh_r <= '0;
      byp_r   <= 1'b0;
    end else if (tck_rise) begin
      if (tap_r == TAP_CAP_DR) begin
        dr_sh_r <= '0;
        byp_r   <= 1'b0;
      end else if (tap_r == TAP_SH_DR) begin
        dr_sh_r <= {sync2_r[S_TDI], dr_sh_r[PROG_DR_W-1:1]};
        byp_r   <= sync2_r[S_TDI];
      end
    end
  end

  assign cf_start = tck_rise & (tap_r == TAP_UPD_IR) & (ir_sh_r == IR_CONFIG);
  assign prog_wr  = tck_rise & (tap_r == TAP_UPD_DR) & (ir_r == IR_PROGRAM) & isp_r;

  // Modes hold until the controller returns to its reset state
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      isp_r   <= 1'b0;
      clamp_r <= 1'b0;
    end else if (tck_rise && tap_r == TAP_RESET) begin
      isp_r   <= 1'b0;
      clamp_r <= 1'b0;
    end else if (tck_rise && tap_r == TAP_UPD_IR) begin
      isp_r   <= isp_r | (ir_sh_r == IR_ISP_ENABLE);
      clamp_r <= clamp_r | (ir_sh_r == IR_CLAMP);
    end
  end

  // Storage holds data only, so it carries no reset
  always_ff @(posedge SYS_CLK_I) begin
    if (prog_wr) begin
      mem_r[dr_sh_r[PROG_DR_W-1:WORD_W]] <= dr_sh_r[WORD_W-1:0];
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_r <= (tap_r == TAP_SH_IR) | (tap_r == TAP_SH_DR);
      if (tap_r == TAP_SH_IR) begin
        tdo_r <= ir_sh_r[0];
      end else if (ir_r == IR_PROGRAM) begin
        tdo_r <= dr_sh_r[0];
      end else begin
        tdo_r <= byp_r;
      end
    end
  end

  assign TDO_O    = tdo_r;
  assign TDO_OE_O = tdo_oe_r;

  // Restarts on every reconfigure so back-to-back commands each get a full pulse
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cf_cnt_r <= '0;
    end else if (cf_start) begin
      cf_cnt_r <= CFG_PULSE_CYCLES;
    end else if (cf_cnt_r != '0) begin
      cf_cnt_r <= cf_cnt_r - CF_CNT_W'(1);
    end
  end

  assign RECONFIG_PULSE_N_O    = 1'b0;
  assign RECONFIG_PULSE_N_OE_O = (cf_cnt_r != '0);

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  a_count_advance: assert property (cfg_rise && !past_r && addr_r != COUNTER_LIMIT |=> addr_r == $past(addr_r) + 8'h01)
    else $error("address counter did not step on clock rise");
  a_reset_hold: assert property (oe_low |-> !SERIAL_DATA_OUT_OE_O ##1 addr_r == '0)
    else $error("reset pin low did not clear counter or float data");
  a_por_pull: assert property (!por_done_r |-> OE_RESET_N_OE_O && !OE_RESET_N_O)
    else $error("reset pin not pulled low during power-on");
  a_standby_float: assert property (sync2_r[S_CE_N] |-> !SERIAL_DATA_OUT_OE_O ##1 addr_r == '0)
    else $error("standby did not clear counter or float data");
  a_config_start: assert property (cf_start |=> RECONFIG_PULSE_N_OE_O && !RECONFIG_PULSE_N_O)
    else $error("reconfigure did not pull configuration pin");
  a_pulse_width: assert property ($rose(RECONFIG_PULSE_N_OE_O) |-> RECONFIG_PULSE_N_OE_O [*3])
    else $error("configuration pulse shorter than minimum");
  a_cascade_low: assert property (!CASCADE_ENABLE_OUT_N_O |-> enabled && past_r && addr_r == COUNTER_LIMIT)
    else $error("cascade output low without exhausted counter");
  a_cascade_high: assert property (oe_low || sync2_r[S_CE_N] |-> CASCADE_ENABLE_OUT_N_O)
    else $error("cascade output not high while disabled");
  a_isp_float: assert property (isp_r && !clamp_r |-> !SERIAL_DATA_OUT_OE_O)
    else $error("data driven in programming mode");
  a_tap_step: assert property (tck_rise && tap_r == TAP_SEL_IR && sync2_r[S_TMS] |=> tap_r == TAP_RESET)
    else $error("controller missed mode select transition");
  a_ir_shift: assert property (tck_rise && tap_r == TAP_SH_IR |=> ir_sh_r[IR_W-1] == $past(sync2_r[S_TDI]))
    else $error("test data not shifted into instruction register");
  a_data_order: assert property (SERIAL_DATA_OUT_OE_O && !prog_wr |-> SERIAL_DATA_OUT_O == mem_r[addr_r[ADDR_W-1:3]][addr_r[2:0]])
    else $error("output bit does not match counter address");
endmodule // scp_readout

// *** scp_pkg.sv ***
// Constants, instruction codes and types shared by the configuration readout block
package scp_pkg;
  localparam int SYS_PERIOD_NS    = 100;
  // Storage: 32 words of 8 bits, read out as 256 bits in address order
  localparam int MEM_WORDS        = 32;
  localparam int WORD_W           = 8;
  localparam int ADDR_W           = 8;
  localparam int WADDR_W          = 5;
  localparam logic [ADDR_W-1:0] COUNTER_LIMIT = 8'hFF;
  // Power-on reset hold time
  localparam int POR_TIME_NS      = 2000;
  localparam int POR_CNT_W        = 8;
  localparam logic [POR_CNT_W-1:0] POR_CYCLES =
    POR_CNT_W'((POR_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
  // Least low time of the configuration pulse
  localparam int CFG_PULSE_MIN_NS = 300;
  localparam int CF_CNT_W         = 4;
  localparam logic [CF_CNT_W-1:0] CFG_PULSE_CYCLES =
    CF_CNT_W'((CFG_PULSE_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
  // Boundary-scan instruction register
  localparam int IR_W             = 8;
  localparam logic [IR_W-1:0] IR_BYPASS     = 8'hFF;
  localparam logic [IR_W-1:0] IR_CONFIG     = 8'hEE;
  localparam logic [IR_W-1:0] IR_ISP_ENABLE = 8'hE8;
  localparam logic [IR_W-1:0] IR_PROGRAM    = 8'hEA;
  localparam logic [IR_W-1:0] IR_CLAMP      = 8'hFA;
  localparam logic [IR_W-1:0] IR_CAPTURE    = 8'h01;
  // Program data register: word address above data byte
  localparam int PROG_DR_W        = WADDR_W + WORD_W;
  // Data path buffer
  localparam int BUF_WIDTH        = 1;
  localparam int BUF_DEPTH        = 2;
  // Positions in the synchronised pin vector
  localparam int SYNC_W           = 7;
  localparam int S_CFG_CLK        = 0;
  localparam int S_CE_N           = 1;
  localparam int S_OE_RST_N       = 2;
  localparam int S_CLK_SEL        = 3;
  localparam int S_TCK            = 4;
  localparam int S_TMS            = 5;
  localparam int S_TDI            = 6;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
  } scp_tap_t;
endpackage

// *** scp_stream_if.sv ***
// Valid/ready stream carrying readout bits from the fetch logic into the buffer and from the buffer to the data pin
`timescale 1ns/1ps
interface scp_stream_if #(parameter int W = 1);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // scp_stream_if

// *** scp_buf.sv ***
// Two-entry shift buffer; the head entry is always slot zero so it comes from a flop
`timescale 1ns/1ps
module scp_buf #(
  parameter int WIDTH = scp_pkg::BUF_WIDTH,
  parameter int DEPTH = scp_pkg::BUF_DEPTH
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic flush_i,
  scp_stream_if.snk fill,
  scp_stream_if.src drain
);
  import scp_pkg::*;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] data_r [DEPTH];
  logic [CW-1:0]    cnt_r;
  logic [CW-1:0]    wr_idx;
  logic             push;
  logic             pop;

  assign pop         = drain.valid & drain.ready;
  assign push        = fill.valid & fill.ready;
  // A pop frees a slot in the same cycle, so a full buffer still takes a word
  assign fill.ready  = (cnt_r != CNT_FULL) | pop;
  assign drain.valid = (cnt_r != '0);
  assign drain.data  = data_r[0];
  assign wr_idx      = cnt_r - CW'(pop);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else if (flush_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        data_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (push && !flush_i && i == int'(wr_idx)) begin
          data_r[i] <= fill.data;
        end else if (pop && i < DEPTH - 1) begin
          data_r[i] <= data_r[i+1];
        end
      end
    end
  end
endmodule // scp_buf

// *** scp_fpga_model.sv ***
// Behavioural configuration-side partner: clocks the readout link and captures each bit
`timescale 1ns/1ps
module scp_fpga_model (
  input  wire logic         clk_i,
  input  wire logic         start_i,
  input  wire logic         slow_i,
  input  wire logic [8:0]   count_i,
  input  wire logic         data_i,
  input  wire logic         data_oe_i,
  output var  logic         cfg_clk_o,
  output var  logic         busy_o,
  output var  logic [255:0] got_o,
  output var  logic [255:0] got_oe_o
);
  int n;
  int low_ns;
  initial begin
    cfg_clk_o = 1'h0;
    busy_o    = 1'h0;
    got_o     = '0;
    got_oe_o  = '0;
    forever begin
      @(posedge clk_i iff start_i);
      busy_o = 1'h1;
      n      = count_i;
      low_ns = slow_i ? 1600 : 400;
      // Odd offset keeps the link clock out of phase with the system clock
      #137;
      for (int k = 0; k < n; k++) begin
        cfg_clk_o   = 1'h1;
        got_o[k]    = data_i;
        got_oe_o[k] = data_oe_i;
        #400;
        cfg_clk_o = 1'h0;
        #(low_ns);
      end
      // Link clock stands low between frames
      busy_o = 1'h0;
    end
  end
endmodule // scp_fpga_model

// *** scp_readout_tb.sv ***
// Self-checking bench for the configuration readout block
`timescale 1ns/1ps
module scp_readout_tb;
  import scp_pkg::*;
  logic         SYS_CLK_I, RESET_N_I, CFG_CLK_SEL_I, CHIP_ENABLE_N_I, TCK_I, TMS_I, TDI_I;
  wire  logic   CFG_CLK_I, OE_RESET_N_O, OE_RESET_N_OE_O, SERIAL_DATA_OUT_O, SERIAL_DATA_OUT_OE_O;
  wire  logic   CASCADE_ENABLE_OUT_N_O, RECONFIG_PULSE_N_O, RECONFIG_PULSE_N_OE_O, TDO_O, TDO_OE_O;
  wire  logic   oe_pin_w, sdata_w, busy;
  wire  logic [255:0] got, got_oe;
  logic         pull_r, last_r, start_r, slow_r;
  logic [8:0]   count_r;
  logic [7:0]   mem [MEM_WORDS];
  logic [7:0]   cap;
  logic [12:0]  dro;
  int           n_errors, compares, seed, pcnt, base, r;

  // Reset pin has a pull-up; both sides may pull it low
  assign oe_pin_w = !((OE_RESET_N_OE_O && !OE_RESET_N_O) || pull_r);
  // Released data line shows the inverse of its last level so a float never reads as valid
  assign sdata_w  = SERIAL_DATA_OUT_OE_O ? SERIAL_DATA_OUT_O : !last_r;
  always @(posedge SYS_CLK_I) begin
    if (SERIAL_DATA_OUT_OE_O) last_r <= SERIAL_DATA_OUT_O;
    if (RECONFIG_PULSE_N_OE_O && !RECONFIG_PULSE_N_O) pcnt <= pcnt + 1;
  end

  scp_readout dut_u (.SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .CFG_CLK_I(CFG_CLK_I),
    .CFG_CLK_SEL_I(CFG_CLK_SEL_I), .CHIP_ENABLE_N_I(CHIP_ENABLE_N_I), .OE_RESET_N_I(oe_pin_w),
    .OE_RESET_N_O(OE_RESET_N_O), .OE_RESET_N_OE_O(OE_RESET_N_OE_O), .SERIAL_DATA_OUT_O(SERIAL_DATA_OUT_O),
    .SERIAL_DATA_OUT_OE_O(SERIAL_DATA_OUT_OE_O), .CASCADE_ENABLE_OUT_N_O(CASCADE_ENABLE_OUT_N_O),
    .RECONFIG_PULSE_N_O(RECONFIG_PULSE_N_O), .RECONFIG_PULSE_N_OE_O(RECONFIG_PULSE_N_OE_O),
    .TCK_I(TCK_I), .TMS_I(TMS_I), .TDI_I(TDI_I), .TDO_O(TDO_O), .TDO_OE_O(TDO_OE_O));

  scp_fpga_model fpga_u (.clk_i(SYS_CLK_I), .start_i(start_r), .slow_i(slow_r), .count_i(count_r),
    .data_i(sdata_w), .data_oe_i(SERIAL_DATA_OUT_OE_O), .cfg_clk_o(CFG_CLK_I), .busy_o(busy),
    .got_o(got), .got_oe_o(got_oe));

  initial begin
    SYS_CLK_I = 1'h0;
    forever #(SYS_PERIOD_NS / 2) SYS_CLK_I = !SYS_CLK_I;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge SYS_CLK_I);
  endtask

  task automatic results;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic exp_bit(input int i);
    return mem[i >> 3][i & 7];
  endfunction

  // Test clock is slow against the system clock: five cycles low, six high
  task automatic tck(input logic tms, input logic tdi, output logic tdo);
    @(posedge SYS_CLK_I);
    TMS_I <= tms;
    TDI_I <= tdi;
    TCK_I <= 1'h0;
    cyc(4);
    @(negedge SYS_CLK_I);
    tdo = TDO_O;
    @(posedge SYS_CLK_I);
    TCK_I <= 1'h1;
    cyc(5);
  endtask

  task automatic tap_reset;
    logic d;
    repeat (5) tck(1'h1, 1'h0, d);
    tck(1'h0, 1'h0, d);
  endtask

  task automatic scan_ir(input logic [7:0] code, output logic [7:0] c);
    logic d;
    tck(1'h1, 1'h0, d);
    tck(1'h1, 1'h0, d);
    tck(1'h0, 1'h0, d);
    tck(1'h0, 1'h0, d);
    for (int i = 0; i < IR_W; i++) tck(i == IR_W - 1, code[i], c[i]);
    tck(1'h1, 1'h0, d);
    tck(1'h0, 1'h0, d);
  endtask

  task automatic scan_dr(input logic [12:0] v, output logic [12:0] o);
    logic d;
    tck(1'h1, 1'h0, d);
    tck(1'h0, 1'h0, d);
    tck(1'h0, 1'h0, d);
    for (int i = 0; i < PROG_DR_W; i++) tck(i == PROG_DR_W - 1, v[i], o[i]);
    tck(1'h1, 1'h0, d);
    tck(1'h0, 1'h0, d);
  endtask

  // Mode 0: data must float; 1: bits in address order from first; 2: counter must not move
  task automatic frame(input int n, input int first, input int mode);
    @(posedge SYS_CLK_I);
    start_r <= 1'h1;
    count_r <= 9'(n);
    @(posedge SYS_CLK_I);
    start_r <= 1'h0;
    @(posedge SYS_CLK_I);
    for (int t = 0; t < 30000 && busy; t++) @(posedge SYS_CLK_I);
    cyc(4);
    for (int k = 0; k < n; k++) begin
      if (mode == 0) chk("float", 16'(got_oe[k]), 16'h0000);
      else chk("bit", 16'({got_oe[k], got[k]}), 16'({1'h1, exp_bit(mode == 1 ? first + k : first)}));
    end
  endtask

  initial begin
    repeat (50000) @(posedge SYS_CLK_I);
    n_errors++;
    results;
  end

  initial begin
    seed = 18;
    n_errors = 0;
    compares = 0;
    RESET_N_I = 1'h0;
    CHIP_ENABLE_N_I = 1'h1;
    CFG_CLK_SEL_I = 1'h1;
    TCK_I = 1'h0;
    TMS_I = 1'h1;
    TDI_I = 1'h0;
    {pull_r, start_r, slow_r} = 3'h0;
    count_r = 9'h000;
    cyc(8);
    RESET_N_I <= 1'h1;
    cyc(19);
    @(negedge SYS_CLK_I);
    chk("por_hold", 16'(OE_RESET_N_OE_O), 16'h0001);
    chk("cascade_idle", 16'(CASCADE_ENABLE_OUT_N_O), 16'h0001);
    chk("cf_idle", 16'(RECONFIG_PULSE_N_OE_O), 16'h0000);
    cyc(2);
    @(negedge SYS_CLK_I);
    chk("por_release", 16'(OE_RESET_N_OE_O), 16'h0000);
    tap_reset();
    chk("tdo_float", 16'(TDO_OE_O), 16'h0000);
    scan_ir(IR_BYPASS, cap);
    chk("ir_capture", 16'(cap), 16'h0001);
    r = $random(seed);
    scan_dr(13'(r), dro);
    chk("bypass", 16'(dro[12:1]), 16'(r[11:0]));
    // Storage is blank until programmed, so the readout is first enabled inside programming mode
    scan_ir(IR_ISP_ENABLE, cap);
    CHIP_ENABLE_N_I <= 1'h0;
    cyc(6);
    chk("isp_float", 16'(SERIAL_DATA_OUT_OE_O), 16'h0000);
    scan_ir(IR_PROGRAM, cap);
    for (int w = 0; w < MEM_WORDS; w++) begin
      mem[w] = 8'($random(seed));
      scan_dr({5'(w), mem[w]}, dro);
    end
    scan_ir(IR_CLAMP, cap);
    cyc(4);
    chk("isp_clamped", 16'(SERIAL_DATA_OUT_OE_O), 16'h0001);
    // Leaving ISP mode, then a write that must be ignored
    tap_reset();
    scan_ir(IR_PROGRAM, cap);
    scan_dr({5'h00, ~mem[0]}, dro);
    cyc(4);
    chk("isp_off", 16'(SERIAL_DATA_OUT_OE_O), 16'h0001);
    chk("data_on", 16'({SERIAL_DATA_OUT_OE_O, SERIAL_DATA_OUT_O}), 16'({1'h1, exp_bit(0)}));
    CFG_CLK_SEL_I <= 1'h0;
    cyc(4);
    frame(3, 0, 2);
    CFG_CLK_SEL_I <= 1'h1;
    cyc(4);
    frame(8, 0, 1);
    frame(247, 8, 1);
    chk("cascade_before", 16'(CASCADE_ENABLE_OUT_N_O), 16'h0001);
    frame(1, 255, 1);
    chk("cascade_past", 16'(CASCADE_ENABLE_OUT_N_O), 16'h0000);
    frame(2, 0, 0);
    CHIP_ENABLE_N_I <= 1'h1;
    cyc(4);
    chk("ce_cascade", 16'(CASCADE_ENABLE_OUT_N_O), 16'h0001);
    chk("ce_float", 16'(SERIAL_DATA_OUT_OE_O), 16'h0000);
    CHIP_ENABLE_N_I <= 1'h0;
    slow_r <= 1'($random(seed));
    cyc(6);
    r = 1 + ($random(seed) & 31);
    frame(r, 0, 1);
    frame(256 - r, r, 1);
    chk("cascade_again", 16'(CASCADE_ENABLE_OUT_N_O), 16'h0000);
    pull_r <= 1'h1;
    cyc(4);
    chk("pin_cascade", 16'(CASCADE_ENABLE_OUT_N_O), 16'h0001);
    chk("pin_float", 16'(SERIAL_DATA_OUT_OE_O), 16'h0000);
    pull_r <= 1'h0;
    cyc(6);
    frame(8, 0, 1);
    for (int i = 0; i < 2; i++) begin
      @(negedge SYS_CLK_I);
      base = pcnt;
      scan_ir(IR_CONFIG, cap);
      cyc(6);
      @(negedge SYS_CLK_I);
      chk("cf_pulse", 16'(pcnt - base), 16'(CFG_PULSE_CYCLES));
    end
    results();
  end
endmodule // scp_readout_tb
